// ===== logic/hsts_consts.svh
// constants and rule summary for the hot swap timer sequencer
// What this block does
// - start-up limit only counts while the output good flag is low.
// - pin and register inrush limits both set: take the lower one.
// - register code gives normal reference times (code plus one) over 16.
// - start-up limit register resets to its largest code.
// - the lowest active limit reference wins, so foldback can take over.
// - selected limit reference never drops below 100 mV.
// - short reset after supply lockout holds gate and timer node low.
// - after reset, small pull-up charges timer until 1.0 V threshold.
// - initial cycle lasts at least 27 ms; pull-up stays on until then.
// - then strong pull-down discharges timer below 0.2 V, ending the cycle.
// - power-up starts only if the supply window inputs are both good.
// - at breaker trip, enable timer fault pull-up and regulate the gate.
// - trip gone before high threshold: fault pull-up off, weak pull-down on.
// - trip level sits a small offset below the current limit.
// - timer high under overcurrent: gate off, fault at once, good flag off.
// - latch-off: weak pull-down at high threshold, no turn-on while discharging.
// - below low threshold, re-enable by supply toggle or operation off then on.
// - retry input high latches off; low retries 10 s after the fault.
// - fault pin stays set until enable edge, off-to-on or power cycle.
`ifndef HSTS_CONSTS_SVH
`define HSTS_CONSTS_SVH

`define HSTS_CLK_MHZ 20
`define HSTS_RST_HOLD_US 1
`define HSTS_INIT_MIN_US 27000
`define HSTS_RETRY_US 10000000

`define HSTS_CMD_OPERATION 8'h01
`define HSTS_CMD_POWER_CYCLE 8'hd9
`define HSTS_CMD_STATUS 8'hd0
`define HSTS_CMD_STARTUP_LIM 8'hf6

`define HSTS_OP_ON_BIT 7
`define HSTS_STARTUP_LIM_RST 4'hf
`define HSTS_FRAC_ONE 5'h01
`define HSTS_LIM_FLOOR_MV 12'h064
`define HSTS_TRIP_OFFSET_MV 12'h02c

`define HSTS_SYNC_W 9
`define HSTS_IN_TRIP 0
`define HSTS_IN_THIGH 1
`define HSTS_IN_TLOW 2
`define HSTS_IN_UV_OK 3
`define HSTS_IN_OV 4
`define HSTS_IN_PGIN 5
`define HSTS_IN_GATE_ENH 6
`define HSTS_IN_ENABLE 7
`define HSTS_IN_RETRY_N 8

`endif

// ===== logic/hsts_pkg.sv
// types shared by the hot swap timer sequencer
package hsts_pkg;
    typedef enum logic [2:0] {
        HSTS_RESET     = 3'h0,
        HSTS_INIT_UP   = 3'h1,
        HSTS_INIT_DOWN = 3'h3,
        HSTS_WAIT_ON   = 3'h2,
        HSTS_RUN       = 3'h6,
        HSTS_RETRY     = 3'h4,
        HSTS_LATCH     = 3'h7
    } hsts_state_t;
endpackage : hsts_pkg

// ===== logic/hsts_sync_bank.sv
// two-flop synchroniser bank for the comparator and pin inputs
`timescale 1ns/1ns
module hsts_sync_bank #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    // one bit per lane; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_lane
            always_ff @(posedge ref_clk) begin
                if (!nrst) begin
                    stage1_ff[i] <= 1'b0;
                    stage2_ff[i] <= 1'b0;
                end else begin
                    stage1_ff[i] <= asyncIn[i];
                    stage2_ff[i] <= stage1_ff[i];
                end
            end
        end
    endgenerate

    assign syncOut = stage2_ff;
endmodule : hsts_sync_bank

// ===== logic/hsts_timer_seq.sv
// hot swap timer sequencer: initial cycle, fault timer, limit selection, command port
`timescale 1ns/1ns
`include "hsts_consts.svh"
module hsts_timer_seq import hsts_pkg::*; #(
    parameter int unsigned INIT_MIN_CYC = `HSTS_INIT_MIN_US * `HSTS_CLK_MHZ,
    parameter int unsigned RETRY_CYC = `HSTS_RETRY_US * `HSTS_CLK_MHZ
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic senseTripCmp,
    input wire logic delayHighCmp,
    input wire logic delayLowCmp,
    input wire logic supplyLowSense,
    input wire logic supplyHighSense,
    input wire logic outputGoodSense,
    input wire logic gateEnhancedCmp,
    input wire logic enablePin,
    input wire logic retryPinN,
    input wire logic [11:0] normalLimitRef,
    input wire logic [11:0] fetPowerLimitRef,
    input wire logic [11:0] inrushLimitRef,
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [7:0] cmdCode,
    input wire logic [7:0] cmdWrData,
    output logic gateDrive,
    output logic gateRegulate,
    output logic gatePullDown,
    output logic timerUpStart,
    output logic timerUpFault,
    output logic timerDownWeak,
    output logic timerDownStrong,
    output logic faultPinOe,
    output logic outputGoodFlag,
    output logic [11:0] limitRefSel,
    output logic [11:0] breakerTripLevel,
    output logic rspValid,
    output logic [7:0] rspData
);
    localparam int unsigned RST_HOLD_CYC = `HSTS_RST_HOLD_US * `HSTS_CLK_MHZ;

    // synchronised comparator and pin levels
    logic [`HSTS_SYNC_W-1:0] syncV;
    logic tripS;
    logic highS;
    logic lowS;
    logic windowOk;
    logic enableS;
    logic retryLowS;

    hsts_sync_bank #(
        .WIDTH(`HSTS_SYNC_W)
    ) uSync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .asyncIn({retryPinN, enablePin, gateEnhancedCmp, outputGoodSense,
                  supplyHighSense, supplyLowSense, delayLowCmp, delayHighCmp,
                  senseTripCmp}),
        .syncOut(syncV)
    );

    assign tripS = syncV[`HSTS_IN_TRIP];
    assign highS = syncV[`HSTS_IN_THIGH];
    assign lowS = syncV[`HSTS_IN_TLOW];
    assign windowOk = syncV[`HSTS_IN_UV_OK] & ~syncV[`HSTS_IN_OV];
    assign enableS = syncV[`HSTS_IN_ENABLE];
    assign retryLowS = ~syncV[`HSTS_IN_RETRY_N];

    // registers
    hsts_state_t state_ff;
    hsts_state_t nxtState;
    logic [27:0] cnt_ff;
    logic [3:0] startLim_ff;
    logic operationOn_ff;
    logic faultFlag_ff;
    logic rearm_ff;
    logic enPrev_ff;
    logic gateDrive_ff;
    logic gateRegulate_ff;
    logic timerUpStart_ff;
    logic timerUpFault_ff;
    logic timerDownWeak_ff;
    logic timerDownStrong_ff;
    logic outputGood_ff;
    logic [11:0] limitRef_ff;
    logic [11:0] tripLevel_ff;
    logic rspValid_ff;
    logic [7:0] rspData_ff;

    // command decode
    logic wrCmd;
    logic opOnCmd;
    logic opOffCmd;
    logic powerCycleCmd;
    logic enRise;
    logic faultEvt;
    logic faultClearReq;

    assign wrCmd = cmdValid & cmdWrite;
    assign opOnCmd = wrCmd & (cmdCode == `HSTS_CMD_OPERATION)
                     & cmdWrData[`HSTS_OP_ON_BIT] & ~operationOn_ff;
    assign opOffCmd = wrCmd & (cmdCode == `HSTS_CMD_OPERATION)
                      & ~cmdWrData[`HSTS_OP_ON_BIT];
    assign powerCycleCmd = wrCmd & (cmdCode == `HSTS_CMD_POWER_CYCLE);
    // the synchroniser leaves reset low, so its first rise is not a real enable edge
    assign enRise = enableS & ~enPrev_ff & (state_ff != HSTS_RESET);
    // continuous overcurrent has carried the timer to its high threshold
    assign faultEvt = (state_ff == HSTS_RUN) & tripS & highS;
    // a clear is refused while the overcurrent is still present
    assign faultClearReq = (enRise | opOnCmd | powerCycleCmd) & ~tripS;

    // next state of the sequencer
    always_comb begin
        nxtState = state_ff;
        case (state_ff)
            HSTS_RESET: begin
                // gate and timer held low for the short reset period
                if (cnt_ff >= 28'(RST_HOLD_CYC - 1)) begin
                    nxtState = HSTS_INIT_UP;
                end
            end
            HSTS_INIT_UP: begin
                // both the threshold and the 27 ms floor must be met
                if (highS && cnt_ff >= 28'(INIT_MIN_CYC - 1)) begin
                    nxtState = HSTS_INIT_DOWN;
                end
            end
            HSTS_INIT_DOWN: begin
                if (lowS) begin
                    nxtState = HSTS_WAIT_ON;
                end
            end
            HSTS_WAIT_ON: begin
                if (windowOk && enableS && operationOn_ff) begin
                    nxtState = HSTS_RUN;
                end
            end
            HSTS_RUN: begin
                if (faultEvt) begin
                    nxtState = retryLowS ? HSTS_RETRY : HSTS_LATCH;
                end else if (!windowOk || !enableS || !operationOn_ff) begin
                    nxtState = HSTS_WAIT_ON;
                end
            end
            HSTS_RETRY: begin
                if (cnt_ff >= 28'(RETRY_CYC - 1)) begin
                    nxtState = HSTS_WAIT_ON;
                end
            end
            HSTS_LATCH: begin
                // held off until the timer is discharged and a supply drop, operation off or power cycle re-arms
                if (lowS && (rearm_ff || powerCycleCmd)) begin
                    nxtState = HSTS_WAIT_ON;
                end
            end
            default: begin
                nxtState = HSTS_RESET;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_ff <= HSTS_RESET;
        end else begin
            state_ff <= nxtState;
        end
    end

    // phase counter, restarts on every state change
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cnt_ff <= 28'h0000000;
        end else if (nxtState != state_ff) begin
            cnt_ff <= 28'h0000000;
        end else if (cnt_ff != 28'hfffffff) begin
            cnt_ff <= cnt_ff + 28'h0000001;
        end
    end

    // start-up pull-up span counted apart from the phase counter, for a_init_min
    logic [27:0] upSpan_ff;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            upSpan_ff <= 28'h0000000;
        end else if (!timerUpStart_ff) begin
            upSpan_ff <= 28'h0000000;
        end else if (upSpan_ff != 28'hfffffff) begin
            upSpan_ff <= upSpan_ff + 28'h0000001;
        end
    end

    // re-arm after latch-off: supply window dropped or operation turned off
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rearm_ff <= 1'b0;
        end else if (state_ff != HSTS_LATCH) begin
            rearm_ff <= 1'b0;
        end else if (!windowOk || opOffCmd) begin
            rearm_ff <= 1'b1;
        end
    end

    // operation on bit and enable edge history
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            operationOn_ff <= 1'b1;
            enPrev_ff <= 1'b0;
        end else begin
            enPrev_ff <= enableS;
            if (wrCmd && cmdCode == `HSTS_CMD_OPERATION) begin
                operationOn_ff <= cmdWrData[`HSTS_OP_ON_BIT];
            end
        end
    end

    // start-up limit fraction register
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            startLim_ff <= `HSTS_STARTUP_LIM_RST;
        end else if (wrCmd && cmdCode == `HSTS_CMD_STARTUP_LIM) begin
            startLim_ff <= cmdWrData[3:0];
        end
    end

    // latched fault; a new fault in the clearing cycle wins
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            faultFlag_ff <= 1'b0;
        end else if (faultEvt) begin
            faultFlag_ff <= 1'b1;
        end else if (faultClearReq) begin
            faultFlag_ff <= 1'b0;
        end
    end

    // drive outputs follow the next state so they change with it
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            gateDrive_ff <= 1'b0;
            gateRegulate_ff <= 1'b0;
            timerUpStart_ff <= 1'b0;
            timerUpFault_ff <= 1'b0;
            timerDownWeak_ff <= 1'b0;
            timerDownStrong_ff <= 1'b1;
        end else begin
            gateDrive_ff <= (nxtState == HSTS_RUN);
            gateRegulate_ff <= (nxtState == HSTS_RUN) && tripS;
            timerUpStart_ff <= (nxtState == HSTS_INIT_UP);
            timerUpFault_ff <= (nxtState == HSTS_RUN) && tripS;
            timerDownWeak_ff <= ((nxtState == HSTS_RUN) && !tripS)
                                || (nxtState == HSTS_LATCH)
                                || (nxtState == HSTS_RETRY);
            timerDownStrong_ff <= (nxtState == HSTS_RESET)
                                  || (nxtState == HSTS_INIT_DOWN);
        end
    end

    // output good: running, output above threshold, gate enhanced, no fault
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            outputGood_ff <= 1'b0;
        end else begin
            outputGood_ff <= (nxtState == HSTS_RUN) && syncV[`HSTS_IN_PGIN]
                             && syncV[`HSTS_IN_GATE_ENH] && !faultFlag_ff
                             && !faultEvt;
        end
    end

    // current-limit reference selection
    logic [16:0] fracProd;
    logic [11:0] fracRef;
    logic [11:0] inrushRef;
    logic [11:0] lowestRef;

    always_comb begin
        fracProd = 17'(normalLimitRef) * 17'(5'(startLim_ff) + `HSTS_FRAC_ONE);
        fracRef = fracProd[15:4];
        // pin and register limits both apply; the lower one is taken
        inrushRef = (inrushLimitRef < fracRef) ? inrushLimitRef : fracRef;
        lowestRef = (fetPowerLimitRef < normalLimitRef) ? fetPowerLimitRef
                                                        : normalLimitRef;
        // start-up limit drops out once the output is good
        if (!outputGood_ff && inrushRef < lowestRef) begin
            lowestRef = inrushRef;
        end
        // floor keeps some current flowing however low the inputs go
        if (lowestRef < `HSTS_LIM_FLOOR_MV) begin
            lowestRef = `HSTS_LIM_FLOOR_MV;
        end
    end

    // selected reference and breaker trip level just below it
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            limitRef_ff <= `HSTS_LIM_FLOOR_MV;
            tripLevel_ff <= `HSTS_LIM_FLOOR_MV - `HSTS_TRIP_OFFSET_MV;
        end else begin
            limitRef_ff <= lowestRef;
            tripLevel_ff <= lowestRef - `HSTS_TRIP_OFFSET_MV;
        end
    end

    // read answers one cycle after the request; unmapped codes read zero
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rspValid_ff <= 1'b0;
            rspData_ff <= 8'h00;
        end else begin
            rspValid_ff <= cmdValid && !cmdWrite;
            if (cmdValid && !cmdWrite) begin
                case (cmdCode)
                    `HSTS_CMD_STARTUP_LIM: rspData_ff <= {4'h0, startLim_ff};
                    `HSTS_CMD_OPERATION: rspData_ff <= {operationOn_ff, 7'h00};
                    `HSTS_CMD_STATUS: rspData_ff <= {faultFlag_ff, outputGood_ff,
                                                     retryLowS, rearm_ff, 1'b0,
                                                     state_ff};
                    default: rspData_ff <= 8'h00;
                endcase
            end
        end
    end

    assign gateDrive = gateDrive_ff;
    assign gateRegulate = gateRegulate_ff;
    assign gatePullDown = timerDownStrong_ff;
    assign timerUpStart = timerUpStart_ff;
    assign timerUpFault = timerUpFault_ff;
    assign timerDownWeak = timerDownWeak_ff;
    assign timerDownStrong = timerDownStrong_ff;
    assign faultPinOe = faultFlag_ff;
    assign outputGoodFlag = outputGood_ff;
    assign limitRefSel = limitRef_ff;
    assign breakerTripLevel = tripLevel_ff;
    assign rspValid = rspValid_ff;
    assign rspData = rspData_ff;

    // checks on the sequencer behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_overcurrent_done;
        faultEvt;
    endsequence

    sequence s_shut_and_flag;
        !gateDrive_ff && faultFlag_ff && !outputGood_ff;
    endsequence

    a_ref_floor: assert property (limitRef_ff >= `HSTS_LIM_FLOOR_MV)
        else $error("limit reference below floor");
    a_reset_hold: assert property ((state_ff == HSTS_RESET) |->
        !gateDrive_ff && !timerUpStart_ff && timerDownStrong_ff)
        else $error("gate or timer released during reset hold");
    a_init_min: assert property ($fell(timerUpStart_ff) |->
        upSpan_ff >= INIT_MIN_CYC)
        else $error("initial cycle left before minimum time");
    a_start_window: assert property ($rose(gateDrive_ff) |->
        $past(windowOk) && $past(enableS))
        else $error("gate turned on outside supply window");
    a_trip_pullup: assert property ((state_ff == HSTS_RUN) && tripS
        && (nxtState == HSTS_RUN) |=> timerUpFault_ff && gateRegulate_ff)
        else $error("fault pull-up missing at breaker trip");
    a_trip_release: assert property ((state_ff == HSTS_RUN) && !tripS
        && (nxtState == HSTS_RUN) |=> timerDownWeak_ff && !timerUpFault_ff)
        else $error("weak pull-down missing after trip cleared");
    a_fault_shut: assert property (s_overcurrent_done |=> s_shut_and_flag)
        else $error("overcurrent timeout did not shut down");
    a_latch_refuse: assert property ((state_ff == HSTS_LATCH) && !lowS
        |=> !gateDrive_ff)
        else $error("turned on while timer discharging");
    a_retry_pick: assert property (s_overcurrent_done ##0 retryLowS
        |=> state_ff == HSTS_RETRY)
        else $error("retry mode not entered");
    a_fault_hold: assert property (faultFlag_ff && !faultClearReq
        |=> faultFlag_ff)
        else $error("fault flag dropped without clear");
endmodule : hsts_timer_seq

// ===== verif/hot_swap_timer_sequencer_tb.sv
// self-checking bench for the hot swap timer sequencer
`timescale 1ns/1ns
module hot_swap_timer_sequencer_tb;
    logic ref_clk = 0, nrst = 0, senseTripCmp = 0, supplyLowSense = 0, supplyHighSense = 0;
    logic outputGoodSense = 0, gateEnhancedCmp = 0, enablePin = 1, retryPinN = 1;
    logic [11:0] normalLimitRef = 12'h3e8, fetPowerLimitRef = 12'h7d0, inrushLimitRef = 12'h320;
    logic cmdValid = 0, cmdWrite = 0;
    logic [7:0] cmdCode = 8'h00, cmdWrData = 8'h00, rd;
    logic delayHighCmp, delayLowCmp, gateDrive, gateRegulate, gatePullDown, timerUpStart;
    logic timerUpFault, timerDownWeak, timerDownStrong, faultPinOe, outputGoodFlag, rspValid;
    logic [11:0] limitRefSel, breakerTripLevel;
    logic [7:0] rspData;
    int fails = 0, samples_checked = 0, n;

    always #25 ref_clk = ~ref_clk;

    hsts_timer_seq #(.INIT_MIN_CYC(50), .RETRY_CYC(100)) dut (.ref_clk(ref_clk), .nrst(nrst),
        .senseTripCmp(senseTripCmp), .delayHighCmp(delayHighCmp), .delayLowCmp(delayLowCmp),
        .supplyLowSense(supplyLowSense), .supplyHighSense(supplyHighSense),
        .outputGoodSense(outputGoodSense), .gateEnhancedCmp(gateEnhancedCmp),
        .enablePin(enablePin), .retryPinN(retryPinN), .normalLimitRef(normalLimitRef),
        .fetPowerLimitRef(fetPowerLimitRef), .inrushLimitRef(inrushLimitRef),
        .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWrData(cmdWrData),
        .gateDrive(gateDrive), .gateRegulate(gateRegulate), .gatePullDown(gatePullDown),
        .timerUpStart(timerUpStart), .timerUpFault(timerUpFault),
        .timerDownWeak(timerDownWeak), .timerDownStrong(timerDownStrong),
        .faultPinOe(faultPinOe), .outputGoodFlag(outputGoodFlag), .limitRefSel(limitRefSel),
        .breakerTripLevel(breakerTripLevel), .rspValid(rspValid), .rspData(rspData));

    hsts_timer_node_model node (.ref_clk(ref_clk), .timerUpStart(timerUpStart),
        .timerUpFault(timerUpFault), .timerDownWeak(timerDownWeak),
        .timerDownStrong(timerDownStrong), .delayHighCmp(delayHighCmp),
        .delayLowCmp(delayLowCmp));

    task automatic tally_and_finish;
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // compare tasks, one per result width
    task automatic chk_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic chk_val(input logic [11:0] got, input logic [11:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_val

    // settle point: just after a rising edge
    task automatic step(input int cyc);
        repeat (cyc) @(posedge ref_clk);
        #1;
    endtask : step

    function automatic logic pick(input int sel);
        case (sel)
            0: return timerUpStart;
            1: return timerDownStrong;
            2: return gateDrive;
            3: return timerUpFault;
            4: return timerDownWeak;
            5: return faultPinOe;
            6: return outputGoodFlag;
            default: return delayLowCmp;
        endcase
    endfunction : pick

    // bounded wait; running out ends the run as a failure
    task automatic wait_on(input int sel, input logic val, input int bound);
        for (int i = 0; i < bound && pick(sel) !== val; i++) step(1);
        if (pick(sel) !== val) begin
            fails++;
            $display("MISMATCH t=%0t wait %0d timed out", $time, sel);
            tally_and_finish();
        end
    endtask : wait_on

    task automatic cmd_write(input logic [7:0] code, input logic [7:0] data);
        @(posedge ref_clk);
        cmdValid <= 1'b1;
        cmdWrite <= 1'b1;
        cmdCode <= code;
        cmdWrData <= data;
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        cmdWrite <= 1'b0;
    endtask : cmd_write

    // read answer is a one-cycle pulse, so look every cycle
    task automatic cmd_read(input logic [7:0] code, output logic [7:0] data);
        @(posedge ref_clk);
        cmdValid <= 1'b1;
        cmdWrite <= 1'b0;
        cmdCode <= code;
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        #1;
        for (int i = 0; i < 3 && rspValid !== 1'b1; i++) step(1);
        chk_bit(rspValid, 1'b1, "read answer");
        data = rspData;
    endtask : cmd_read

    task automatic set_lim(input logic [11:0] p, input logic [3:0] code, input logic [11:0] exp);
        cmd_write(8'hf6, {4'h0, code});
        @(posedge ref_clk);
        fetPowerLimitRef <= p;
        step(4);
        chk_val(limitRefSel, exp, "limit");
        chk_val(breakerTripLevel, exp - 12'h02c, "trip");
    endtask : set_lim

    task automatic t_init;
        wait_on(0, 1'b1, 40);
        n = 0;
        while (timerUpStart === 1'b1 && n < 200) begin
            step(1);
            n++;
        end
        chk_bit(n >= 50 && n <= 53, 1'b1, "initial up span");
        chk_bit(timerDownStrong, 1'b1, "initial down");
        wait_on(1, 1'b0, 60);
        chk_bit(delayLowCmp, 1'b1, "ends below low");
        step(20);
        chk_bit(gateDrive, 1'b0, "no start outside window");
        @(posedge ref_clk);
        supplyLowSense <= 1'b1;
        wait_on(2, 1'b1, 10);
    endtask : t_init

    task automatic t_limits;
        cmd_read(8'hf6, rd);
        chk_val({4'h0, rd}, 12'h00f, "fraction reset");
        cmd_read(8'h55, rd);
        chk_val({4'h0, rd}, 12'h000, "unmapped read");
        set_lim(12'h7d0, 4'hf, 12'h320);
        set_lim(12'h7d0, 4'h3, 12'h0fa);
        cmd_read(8'hf6, rd);
        chk_val({4'h0, rd}, 12'h003, "fraction readback");
        set_lim(12'h096, 4'hf, 12'h096);
        set_lim(12'h032, 4'hf, 12'h064);
        @(posedge ref_clk);
        outputGoodSense <= 1'b1;
        gateEnhancedCmp <= 1'b1;
        wait_on(6, 1'b1, 20);
        set_lim(12'h7d0, 4'h0, 12'h3e8);
    endtask : t_limits

    task automatic t_latch;
        @(posedge ref_clk);
        senseTripCmp <= 1'b1;
        wait_on(3, 1'b1, 10);
        chk_bit(gateRegulate, 1'b1, "regulating");
        step(20);
        @(posedge ref_clk);
        senseTripCmp <= 1'b0;
        wait_on(4, 1'b1, 10);
        chk_bit(timerUpFault, 1'b0, "fault pull-up off");
        step(60);
        @(posedge ref_clk);
        senseTripCmp <= 1'b1;
        wait_on(5, 1'b1, 200);
        chk_bit(gateDrive, 1'b0, "gate off");
        chk_bit(outputGoodFlag, 1'b0, "good off");
        chk_bit(timerDownWeak, 1'b1, "latch discharge");
        @(posedge ref_clk);
        senseTripCmp <= 1'b0;
        step(50);
        chk_bit(gateDrive, 1'b0, "stays off");
        wait_on(7, 1'b1, 300);
        cmd_write(8'h01, 8'h00);
        cmd_write(8'h01, 8'h80);
        wait_on(2, 1'b1, 30);
        wait_on(5, 1'b0, 10);
    endtask : t_latch

    task automatic t_retry;
        @(posedge ref_clk);
        retryPinN <= 1'b0;
        step(4);
        @(posedge ref_clk);
        senseTripCmp <= 1'b1;
        wait_on(5, 1'b1, 200);
        @(posedge ref_clk);
        senseTripCmp <= 1'b0;
        step(40);
        chk_bit(gateDrive, 1'b0, "off before retry");
        // fault edge to gate on: 100 retry cycles plus one in the wait state
        n = 41;
        while (gateDrive !== 1'b1 && n < 400) begin
            step(1);
            n++;
        end
        chk_bit(n == 101, 1'b1, "retry delay");
        chk_bit(faultPinOe, 1'b1, "fault kept");
        cmd_write(8'hd9, 8'h00);
        cmd_read(8'hd0, rd);
        chk_val({4'h0, rd}, 12'h066, "status after power cycle");
        chk_bit(faultPinOe, 1'b0, "fault cleared");
    endtask : t_retry

    initial begin
        step(10);
        chk_bit(gatePullDown & timerDownStrong & ~gateDrive, 1'b1, "reset hold");
        chk_val(limitRefSel, 12'h064, "reset limit");
        @(posedge ref_clk);
        @(posedge ref_clk);
        nrst <= 1'b1;
        t_init();
        t_limits();
        t_latch();
        t_retry();
        tally_and_finish();
    end
endmodule : hot_swap_timer_sequencer_tb

// ===== verif/hsts_timer_node_model.sv
// behavioural timer capacitor with its two threshold comparators
`timescale 1ns/1ns
module hsts_timer_node_model (
    input wire logic ref_clk,
    input wire logic timerUpStart,
    input wire logic timerUpFault,
    input wire logic timerDownWeak,
    input wire logic timerDownStrong,
    output logic delayHighCmp,
    output logic delayLowCmp
);
    int nodeMv = 0;
    // fast charge so the INIT_MIN_CYC floor, not the cap, sets the initial cycle
    always @(posedge ref_clk) begin
        if (timerDownStrong) begin
            nodeMv <= (nodeMv > 100) ? nodeMv - 100 : 0;
        end else if (timerDownWeak) begin
            nodeMv <= (nodeMv > 5) ? nodeMv - 5 : 0;
        end else if (timerUpFault) begin
            nodeMv <= nodeMv + 10;
        end else if (timerUpStart) begin
            nodeMv <= (nodeMv < 2600) ? nodeMv + 100 : 2700;
        end
    end
    // thresholds 1.0 V and 0.2 V
    assign delayHighCmp = (nodeMv >= 1000);
    assign delayLowCmp = (nodeMv < 200);
endmodule : hsts_timer_node_model
